// ---- lpd_chk.sv ----
module lpd_chk import lpd_pkg::*; (
	input wire logic        MCLK,
	input wire logic        RST,
	input wire logic        CE,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire lpd_meas_t   MEAS,
	input wire logic        MEAS_VALID,
	input wire logic        POTENTIAL_LOST,
	input wire logic        POTENTIAL_LOST_BLOCK,
	input wire logic        CLOSE_CHECK_HIT,
	input wire logic        VOLT_DROP_HIT,
	input wire logic        LOSS_LATCHED,
	input wire logic        BUSBAR_CHECK_HIT,
	input wire logic        VOLTS_HEALTHY_CLEAR,
	input wire logic        CURRENT_DISTURBANCE
);
	logic [2:0] ctl;
	logic [8:0] dd_n;
	logic [8:0] hit_n;
	logic       iv;
	logic [7:0] st;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// Interval strobe and status word as read back
	assign iv = CE && MEAS_VALID;
	assign st = {CURRENT_DISTURBANCE, VOLTS_HEALTHY_CLEAR, BUSBAR_CHECK_HIT, LOSS_LATCHED,
		VOLT_DROP_HIT, CLOSE_CHECK_HIT, POTENTIAL_LOST_BLOCK, POTENTIAL_LOST};
	// Control shadow and interval counters
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctl   <= 3'h0;
			dd_n  <= 9'h000;
			hit_n <= 9'h000;
		end else begin
			if (CE && REG_WR && REG_ADDR == REG_CTRL)
				ctl <= REG_WDATA[2:0];
			dd_n  <= !CURRENT_DISTURBANCE ? 9'h000 : dd_n + 9'(iv && dd_n != 9'h1FF);
			hit_n <= !(CLOSE_CHECK_HIT || VOLT_DROP_HIT) ? 9'h000 : hit_n + 9'(iv && hit_n != 9'h1FF);
		end
	end
	a_lost_follows_hits: assert property (POTENTIAL_LOST == ((CLOSE_CHECK_HIT || VOLT_DROP_HIT ||
		BUSBAR_CHECK_HIT || LOSS_LATCHED) && !VOLTS_HEALTHY_CLEAR)) else $error("status differs from hits");
	a_block_gated: assert property (POTENTIAL_LOST_BLOCK == (POTENTIAL_LOST &&
		(ctl[1:0] == LPD_EN_Y || ctl[1:0] == LPD_EN_Y1))) else $error("block output wrong");
	a_drop_forced_low: assert property (iv && (MEAS.three_pole_open || MEAS.out_of_step)
		|=> !VOLT_DROP_HIT) else $error("drop hit while open or out of step");
	a_disturb_hold: assert property ($fell(CURRENT_DISTURBANCE)
		|-> dd_n >= DISTURB_COUNT - 9'h001) else $error("disturbance flag short");
	a_latch_count: assert property ($rose(LOSS_LATCHED)
		|-> hit_n >= LATCH_COUNT - 9'h002 && hit_n <= LATCH_COUNT) else $error("latch set at wrong count");
	a_clear_wins: assert property (VOLTS_HEALTHY_CLEAR
		|-> !POTENTIAL_LOST && !LOSS_LATCHED) else $error("status held during clear");
	a_close_gated: assert property (iv && ctl[CTRL_BUSBAR_BIT] |=> !CLOSE_CHECK_HIT)
		else $error("close check with busbar select");
	a_busbar_gated: assert property (iv && !ctl[CTRL_BUSBAR_BIT] |=> !BUSBAR_CHECK_HIT)
		else $error("busbar check without busbar select");
	a_status_read: assert property (CE && REG_RD && REG_ADDR == REG_STATUS
		|=> REG_RDATA[7:0] == $past(st)) else $error("status read mismatch");
endmodule // lpd_chk

bind lpd_detector lpd_chk u_chk (.MCLK, .RST, .CE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
	.MEAS, .MEAS_VALID, .POTENTIAL_LOST, .POTENTIAL_LOST_BLOCK, .CLOSE_CHECK_HIT, .VOLT_DROP_HIT,
	.LOSS_LATCHED, .BUSBAR_CHECK_HIT, .VOLTS_HEALTHY_CLEAR, .CURRENT_DISTURBANCE);

// ---- lpd_detector.sv ----
// Behaviour
// - Potential lost rises with close, drop or busbar hit, same interval.
// - Close or drop hit held 15 cycles sets the latch holding potential lost.
// - Voltages healthy 10 cycles raise a clear flag resetting status and latch.
// - Potential lost status is produced whatever the blocking enable holds.
// - Blocking output follows status only with enable Y or Y1, else low.
// - Close check only with busbar select N, busbar check only with Y.
// - Disturbance flag high when current change seen within last 10 cycles.
// - Falling three-pole-open arms the close check for 20 cycles only.
// - Armed close check asserts after two cycles of voltage and current conditions.
// - Voltage drop hit seals in until a current change or clear condition.
// - Drop may start only when V1 is at most 0.9 of one cycle ago.
// - I1 magnitude change over 10% nominal forces drop hit low.
// - I1 angle change over 5 degrees blocks, ignored below 0.05 nominal.
// - I0 magnitude change over 10% nominal forces drop hit low.
// - I0 angle change over 5 degrees blocks, only above 1.6% nominal.
// - Each current change keeps the drop detector blocked for two cycles.
// - Drop hit only while clear, three-pole-open and out-of-step are low.
// - Busbar select resets to N so the close check is active.
// - Busbar hit sets at near-zero volts without change, clears after healthy.
//
// The register addresses and the address-and-strobe port were left to the implementer.
module lpd_detector
	import lpd_pkg::*;
#(
	parameter logic [7:0] V2V1_FRAC      = V2V1_FRAC_DEF,
	parameter logic [7:0] I0I1_FRAC      = I0I1_FRAC_DEF,
	parameter logic [7:0] I2I1_FRAC      = I2I1_FRAC_DEF,
	parameter logic [7:0] HEALTHY_FRAC   = HEALTHY_FRAC_DEF,
	parameter logic [7:0] NEAR_ZERO_FRAC = NEAR_ZERO_FRAC_DEF
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	input  wire lpd_meas_t   MEAS,
	input  wire logic        MEAS_VALID,
	output logic             POTENTIAL_LOST,
	output logic             POTENTIAL_LOST_BLOCK,
	output logic             CLOSE_CHECK_HIT,
	output logic             VOLT_DROP_HIT,
	output logic             LOSS_LATCHED,
	output logic             BUSBAR_CHECK_HIT,
	output logic             VOLTS_HEALTHY_CLEAR,
	output logic             CURRENT_DISTURBANCE
);

	// Whole module state
	typedef struct packed {
		logic [15:0][15:0] hist_v1;
		logic [15:0][15:0] hist_i1m;
		logic [15:0][15:0] hist_i1a;
		logic [15:0][15:0] hist_i0m;
		logic [15:0][15:0] hist_i0a;
		logic [3:0]        slot;
		logic              hist_full;
		logic [1:0]        loss_block_enable;
		logic              busbar_pt_select;
		logic [15:0]       nominal_voltage;
		logic [15:0]       nominal_current;
		logic [31:0]       rdata;
		logic              tpo_prev;
		logic [8:0]        arm_cnt;
		logic [8:0]        qual_cnt;
		logic [8:0]        change_cnt;
		logic [8:0]        disturb_cnt;
		logic [8:0]        healthy_cnt;
		logic [8:0]        latch_cnt;
		logic              potential_lost;
		logic              potential_lost_block;
		logic              close_check_hit;
		logic              volt_drop_hit;
		logic              loss_latched;
		logic              busbar_check_hit;
		logic              volts_healthy_clear;
		logic              current_disturbance;
	} lpd_state_t;

	lpd_state_t st;
	lpd_state_t next_st;

	// Comparison terms of the present interval
	logic [15:0] v1_old;
	logic [15:0] i1m_old;
	logic [15:0] i1a_old;
	logic [15:0] i0m_old;
	logic [15:0] i0a_old;
	logic        i1_mag_chg;
	logic        i1_ang_chg;
	logic        i0_mag_chg;
	logic        i0_ang_chg;
	logic        change_now;
	logic        change_recent;
	logic        drop_start;
	logic        v2_imbal;
	logic        i0_imbal;
	logic        i2_imbal;
	logic        v1_above_min;
	logic        healthy;
	logic        near_zero;

	// Magnitude difference scaled against tenth of nominal
	function automatic logic mag_change(input logic [15:0] now, input logic [15:0] old,
		input logic [15:0] nominal);
		logic [15:0] diff;
		diff = (now > old) ? now - old : old - now;
		return ({4'h0, diff} * 20'h0000A) > {4'h0, nominal};
	endfunction

	// Wrapped angle difference against the limit
	function automatic logic ang_change(input logic [15:0] now, input logic [15:0] old);
		logic [15:0] diff;
		diff = now - old;
		if (diff[15]) begin
			diff = 16'h0000 - diff;
		end
		return diff > ANGLE_LIMIT;
	endfunction

	// Ratio check: num * 64 above frac * den
	function automatic logic ratio_over(input logic [15:0] num, input logic [15:0] den,
		input logic [7:0] frac);
		return {num, 6'h00} > ({6'h00, den} * {14'h0000, frac});
	endfunction

	// History lookup, one power-system cycle back
	always_comb begin
		v1_old  = st.hist_v1[st.slot];
		i1m_old = st.hist_i1m[st.slot];
		i1a_old = st.hist_i1a[st.slot];
		i0m_old = st.hist_i0m[st.slot];
		i0a_old = st.hist_i0a[st.slot];
	end

	// Current change detectors
	always_comb begin
		i1_mag_chg = st.hist_full && mag_change(MEAS.i1_mag, i1m_old, st.nominal_current);
		i1_ang_chg = st.hist_full && ang_change(MEAS.i1_ang, i1a_old)
			&& ({2'h0, MEAS.i1_mag, 4'h0} + {4'h0, MEAS.i1_mag, 2'h0} >= {6'h00, st.nominal_current});
		i0_mag_chg = st.hist_full && mag_change(MEAS.i0_mag, i0m_old, st.nominal_current);
		i0_ang_chg = st.hist_full && ang_change(MEAS.i0_ang, i0a_old)
			&& (({8'h00, MEAS.i0_mag} * 24'h00007D) > {7'h00, st.nominal_current, 1'b0});
		change_now    = i1_mag_chg | i1_ang_chg | i0_mag_chg | i0_ang_chg;
		change_recent = change_now | (st.change_cnt != 9'h000);
	end

	// Voltage and imbalance checks
	always_comb begin
		drop_start   = st.hist_full
			&& ({4'h0, MEAS.v1_mag} * 20'h0000A <= {4'h0, v1_old} * 20'h00009);
		v2_imbal     = ratio_over(MEAS.v2_mag, MEAS.v1_mag, V2V1_FRAC);
		i0_imbal     = ratio_over(MEAS.i0_mag, MEAS.i1_mag, I0I1_FRAC);
		i2_imbal     = ratio_over(MEAS.i2_mag, MEAS.i1_mag, I2I1_FRAC);
		v1_above_min = MEAS.v1_mag > CLOSE_MIN_CODE;
		// Healthy when V1 * 64 reaches frac * nominal and v2_imbal is low
		healthy      = ({MEAS.v1_mag, 6'h00} >= ({6'h00, st.nominal_voltage} * {14'h0000, HEALTHY_FRAC}))
			&& !v2_imbal;
		near_zero    = !ratio_over(MEAS.v1_mag, st.nominal_voltage, NEAR_ZERO_FRAC);
	end

	// Next state
	always_comb begin
		next_st = st;

		// Register writes
		if (REG_WR) begin
			case (REG_ADDR)
				REG_CTRL: begin
					next_st.loss_block_enable = REG_WDATA[CTRL_ENABLE_LSB +: 2];
					next_st.busbar_pt_select  = REG_WDATA[CTRL_BUSBAR_BIT];
				end
				REG_NOMV: next_st.nominal_voltage = REG_WDATA[15:0];
				REG_NOMI: next_st.nominal_current = REG_WDATA[15:0];
				default: ;
			endcase
		end

		// Register reads, answered next cycle
		next_st.rdata = 32'h00000000;
		if (REG_RD) begin
			case (REG_ADDR)
				REG_CTRL:   next_st.rdata = {29'h00000000, st.busbar_pt_select, st.loss_block_enable};
				REG_NOMV:   next_st.rdata = {16'h0000, st.nominal_voltage};
				REG_NOMI:   next_st.rdata = {16'h0000, st.nominal_current};
				REG_STATUS: next_st.rdata = {24'h000000, st.current_disturbance, st.volts_healthy_clear,
					st.busbar_check_hit, st.loss_latched, st.volt_drop_hit, st.close_check_hit,
					st.potential_lost_block, st.potential_lost};
				default:    next_st.rdata = 32'h00000000;
			endcase
		end

		// Detection advances once per processing interval
		if (MEAS_VALID) begin
			// History ring, SAMPLES_PER_CYCLE deep
			next_st.hist_v1[st.slot]  = MEAS.v1_mag;
			next_st.hist_i1m[st.slot] = MEAS.i1_mag;
			next_st.hist_i1a[st.slot] = MEAS.i1_ang;
			next_st.hist_i0m[st.slot] = MEAS.i0_mag;
			next_st.hist_i0a[st.slot] = MEAS.i0_ang;
			next_st.slot = (st.slot == LAST_SLOT) ? 4'h0 : st.slot + 4'h1;
			if (st.slot == LAST_SLOT) begin
				next_st.hist_full = 1'b1;
			end

			// Change memory and disturbance window
			if (change_now) begin
				next_st.change_cnt  = CHANGE_COUNT;
				next_st.disturb_cnt = DISTURB_COUNT;
			end else begin
				if (st.change_cnt != 9'h000) begin
					next_st.change_cnt = st.change_cnt - 9'h001;
				end
				if (st.disturb_cnt != 9'h000) begin
					next_st.disturb_cnt = st.disturb_cnt - 9'h001;
				end
			end
			next_st.current_disturbance = change_now || (st.disturb_cnt > 9'h001);

			// Healthy-voltage timer and clear flag
			if (!healthy) begin
				next_st.healthy_cnt = 9'h000;
			end else if (st.healthy_cnt != HEALTHY_COUNT) begin
				next_st.healthy_cnt = st.healthy_cnt + 9'h001;
			end
			next_st.volts_healthy_clear = healthy && (st.healthy_cnt >= HEALTHY_COUNT - 9'h001);

			// Arm window on breaker closing
			next_st.tpo_prev = MEAS.three_pole_open;
			if (st.tpo_prev && !MEAS.three_pole_open) begin
				next_st.arm_cnt = ARM_COUNT;
			end else if (st.arm_cnt != 9'h000) begin
				next_st.arm_cnt = st.arm_cnt - 9'h001;
			end

			// Close check qualification
			if ((st.arm_cnt != 9'h000) && v2_imbal && v1_above_min && !i0_imbal && !i2_imbal
				&& !st.busbar_pt_select) begin
				if (st.qual_cnt != QUAL_COUNT) begin
					next_st.qual_cnt = st.qual_cnt + 9'h001;
				end
			end else begin
				next_st.qual_cnt = 9'h000;
			end
			next_st.close_check_hit = (st.arm_cnt != 9'h000) && !st.busbar_pt_select
				&& (next_st.qual_cnt == QUAL_COUNT);

			// Voltage drop detector with seal-in
			if (next_st.volts_healthy_clear || MEAS.three_pole_open || MEAS.out_of_step) begin
				next_st.volt_drop_hit = 1'b0;
			end else if (change_recent) begin
				next_st.volt_drop_hit = 1'b0;
			end else begin
				next_st.volt_drop_hit = st.volt_drop_hit || drop_start;
			end

			// Busbar detector
			if (!st.busbar_pt_select || next_st.volts_healthy_clear) begin
				next_st.busbar_check_hit = 1'b0;
			end else if (near_zero && !change_recent) begin
				next_st.busbar_check_hit = 1'b1;
			end

			// Latch after persistent close or drop hit
			if (next_st.close_check_hit || next_st.volt_drop_hit) begin
				if (st.latch_cnt != LATCH_COUNT) begin
					next_st.latch_cnt = st.latch_cnt + 9'h001;
				end
			end else begin
				next_st.latch_cnt = 9'h000;
			end
			if (next_st.volts_healthy_clear) begin
				next_st.loss_latched = 1'b0;
			end else if (next_st.latch_cnt == LATCH_COUNT) begin
				next_st.loss_latched = 1'b1;
			end

			// Status and blocking outputs
			next_st.potential_lost = !next_st.volts_healthy_clear
				&& (next_st.close_check_hit || next_st.volt_drop_hit
				|| next_st.busbar_check_hit || next_st.loss_latched);
		end

		next_st.potential_lost_block = next_st.potential_lost
			&& ((next_st.loss_block_enable == LPD_EN_Y) || (next_st.loss_block_enable == LPD_EN_Y1));
	end

	// State register
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st <= '0;
			st.nominal_voltage   <= NOMV_RESET;
			st.nominal_current   <= NOMI_RESET;
			st.loss_block_enable <= LPD_EN_N;
			st.busbar_pt_select  <= 1'b0;
		end else if (CE) begin
			st <= next_st;
		end
	end

	// Outputs from state
	always_comb begin
		REG_RDATA            = st.rdata;
		POTENTIAL_LOST       = st.potential_lost;
		POTENTIAL_LOST_BLOCK = st.potential_lost_block;
		CLOSE_CHECK_HIT      = st.close_check_hit;
		VOLT_DROP_HIT        = st.volt_drop_hit;
		LOSS_LATCHED         = st.loss_latched;
		BUSBAR_CHECK_HIT     = st.busbar_check_hit;
		VOLTS_HEALTHY_CLEAR  = st.volts_healthy_clear;
		CURRENT_DISTURBANCE  = st.current_disturbance;
	end

endmodule // lpd_detector

// ---- lpd_front.sv ----
module lpd_front import lpd_pkg::*; (
	input  wire logic      MCLK,
	input  wire logic      RST,
	input  wire lpd_meas_t M_IN,
	output lpd_meas_t      MEAS,
	output logic           MEAS_VALID
);
	// One interval every second clock, data scrambled between strobes
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			MEAS_VALID <= 1'b0;
			MEAS       <= '1;
		end else begin
			MEAS_VALID <= !MEAS_VALID;
			MEAS       <= MEAS_VALID ? ~MEAS : M_IN;
		end
	end
endmodule // lpd_front

// ---- lpd_pkg.sv ----
package lpd_pkg;

	// Sampling and timing, counted in processing intervals
	localparam int unsigned SAMPLES_PER_CYCLE = 16;
	localparam int unsigned LATCH_CYCLES      = 15;
	localparam int unsigned HEALTHY_CYCLES    = 10;
	localparam int unsigned DISTURB_CYCLES    = 10;
	localparam int unsigned ARM_CYCLES        = 20;
	localparam int unsigned QUAL_CYCLES       = 2;
	localparam int unsigned CHANGE_CYCLES     = 2;
	localparam logic [8:0]  LATCH_COUNT   = 9'(LATCH_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [8:0]  HEALTHY_COUNT = 9'(HEALTHY_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [8:0]  DISTURB_COUNT = 9'(DISTURB_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [8:0]  ARM_COUNT     = 9'(ARM_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [8:0]  QUAL_COUNT    = 9'(QUAL_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [8:0]  CHANGE_COUNT  = 9'(CHANGE_CYCLES * SAMPLES_PER_CYCLE);
	localparam logic [3:0]  LAST_SLOT     = 4'(SAMPLES_PER_CYCLE - 1);

	// Scaling: voltage LSB 1/16 V, angle full turn 65536
	localparam int unsigned VOLT_LSB_PER_V = 16;
	localparam int unsigned CLOSE_MIN_V    = 10;
	localparam logic [15:0] CLOSE_MIN_CODE = 16'(CLOSE_MIN_V * VOLT_LSB_PER_V);
	localparam int unsigned ANGLE_LIMIT_DEG = 5;
	localparam logic [15:0] ANGLE_LIMIT    = 16'(ANGLE_LIMIT_DEG * 65536 / 360);

	// Ratio defaults, in 1/64 units
	localparam logic [7:0]  V2V1_FRAC_DEF    = 8'h08;
	localparam logic [7:0]  I0I1_FRAC_DEF    = 8'h04;
	localparam logic [7:0]  I2I1_FRAC_DEF    = 8'h04;
	localparam logic [7:0]  HEALTHY_FRAC_DEF = 8'h30;
	localparam logic [7:0]  NEAR_ZERO_FRAC_DEF = 8'h06;

	// Register map
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_NOMV   = 8'h04;
	localparam logic [7:0]  REG_NOMI   = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0C;
	localparam int unsigned CTRL_ENABLE_LSB = 0;
	localparam int unsigned CTRL_BUSBAR_BIT = 2;
	localparam logic [15:0] NOMV_RESET = 16'h0430;
	localparam logic [15:0] NOMI_RESET = 16'h0500;

	// Blocking enable selections
	typedef enum logic [1:0] {LPD_EN_N = 2'h0, LPD_EN_Y = 2'h1, LPD_EN_Y1 = 2'h2} lpd_enable_t;

	// One processing interval of front-end data
	typedef struct packed {
		logic [15:0] v1_mag;
		logic [15:0] v2_mag;
		logic [15:0] i1_mag;
		logic [15:0] i1_ang;
		logic [15:0] i0_mag;
		logic [15:0] i0_ang;
		logic [15:0] i2_mag;
		logic        three_pole_open;
		logic        out_of_step;
	} lpd_meas_t;

endpackage

// ---- tb_top.sv ----
module tb_top import lpd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst, ce, wr, rd;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	lpd_meas_t   m, meas;
	logic        vld, lost, blk, close, drop, latch, bus, clr, dd;
	int          bad_count, total_checks;
	int          cyc = 0;

	lpd_detector uut (.MCLK(mclk), .RST(rst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .MEAS(meas), .MEAS_VALID(vld), .POTENTIAL_LOST(lost),
		.POTENTIAL_LOST_BLOCK(blk), .CLOSE_CHECK_HIT(close), .VOLT_DROP_HIT(drop), .LOSS_LATCHED(latch),
		.BUSBAR_CHECK_HIT(bus), .VOLTS_HEALTHY_CLEAR(clr), .CURRENT_DISTURBANCE(dd));
	lpd_front u_front (.MCLK(mclk), .RST(rst), .M_IN(m), .MEAS(meas), .MEAS_VALID(vld));

	// Clock and hang limit
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// Fall to 0.9 or less of the value one cycle back
	function automatic logic drops(input logic [15:0] now, input logic [15:0] old);
		return 20'(now) * 20'h0000A <= 20'(old) * 20'h00009;
	endfunction
	function automatic logic blk_exp(input int e);
		return e == int'(LPD_EN_Y) || e == int'(LPD_EN_Y1);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk iff vld);
		@(negedge mclk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		{ce, rst, wr, rd, addr, wdata, m} = '0;
		rst = 1'b1;
		ce = 1'b1;
		void'($urandom(41));
		m.i1_mag = 16'h0200 + 16'($urandom_range(511));
		m.i1_ang = 16'($urandom);
		m.i2_mag = 16'($urandom_range(31));
		m.v1_mag = 16'h0300;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(REG_CTRL, 32'h0);
		rd_reg(8'h10, 32'h0);
		wr_reg(REG_STATUS, '1);
		rd_reg(REG_STATUS, 32'h0);
		$display("test registers done");
		step(16);
		m.v1_mag = 16'h02BC;
		step(16);
		chk(drop, drops(16'h02BC, 16'h0300));
		m.v1_mag = 16'h0100;
		step(1);
		chk(drop, drops(16'h0100, 16'h02BC));
		chk(lost, 1'b1);
		chk(blk, 1'b0);
		for (int e = 0; e < 4; e++) begin
			wr_reg(REG_CTRL, 32'(e));
			step(1);
			chk(blk, blk_exp(e));
			chk(lost, 1'b1);
		end
		wr_reg(REG_CTRL, 32'h1);
		step(200);
		chk(latch, 1'b0);
		chk(drop, 1'b1);
		step(50);
		chk(latch, 1'b1);
		$display("test drop and latch done");
		for (int k = 0; k < 6; k++) begin
			m.v1_mag = 16'h0300;
			m.three_pole_open = 1'b0;
			m.out_of_step = 1'b0;
			if (k == 4)
				m.i0_mag = 16'h0000;
			// Wait out change memory, and the disturbance window before the open and out-of-step cases
			step(k < 4 ? 64 : 200);
			m.v1_mag = 16'h0100;
			step(1);
			chk(drop, 1'b1);
			case (k)
				0: m.i1_mag = m.i1_mag + 16'h0100;
				1: m.i1_ang = m.i1_ang + 16'h0400;
				2: m.i0_mag = m.i0_mag + 16'h0100;
				3: m.i0_ang = m.i0_ang + 16'h0400;
				4: m.three_pole_open = 1'b1;
				default: m.out_of_step = 1'b1;
			endcase
			step(1);
			chk(drop, 1'b0);
			chk(dd, 32'(k < 4));
		end
		m.out_of_step = 1'b0;
		m.v1_mag = 16'h0300;
		m.i1_mag = m.i1_mag + 16'h0100;
		step(17);
		m.v1_mag = 16'h0100;
		step(1);
		chk(drop, 1'b0);
		$display("test current change done");
		m.v1_mag = 16'h0400;
		step(120);
		chk({dd, clr, lost}, 3'h5);
		step(50);
		chk({dd, clr, lost, latch}, 4'h4);
		$display("test healthy done");
		m.v2_mag = 16'h0100;
		m.three_pole_open = 1'b1;
		step(4);
		m.three_pole_open = 1'b0;
		step(20);
		chk(close, 1'b0);
		step(20);
		chk({close, lost, blk}, 3'h7);
		step(300);
		chk({close, latch}, 2'h1);
		$display("test breaker close done");
		wr_reg(REG_CTRL, 32'h4);
		m.v2_mag = 16'h0000;
		m.v1_mag = 16'h0040;
		step(20);
		chk({bus, close, blk, lost}, 4'h9);
		m.v1_mag = 16'h0400;
		step(150);
		chk(bus, 1'b1);
		step(20);
		chk({bus, lost}, 2'h0);
		rd_reg(REG_CTRL, 32'h4);
		rd_reg(REG_STATUS, 32'h40);
		$display("test busbar done");
		stop_test();
	end
endmodule // tb_top
